/* File: rtl/paac_top.sv */
`timescale 1ns/1ps
// Operation
// - reset zeroes event counter, empties store, selects buffer zero.
// - interrupt level and vector come up zero.
// - threshold memory is not reset; host loads every channel first.
// - chain group base comes up 0xAA.
// - gate while idle starts charge conversion, raises busy; counts event with option bit 14 set.
// - fast clear or reset during charge conversion aborts the event.
// - conversion walks the hold stages through the converter one by one.
// - accepted data stored between header and trailer words.
// - nothing accepted and empty option clear: nothing stored.
// - nothing accepted and empty option set: header and trailer only.
// - store not full clears holds and busy; full keeps busy, refuses gates.
// - option bit 0 enables random memory access test.
// - low test half write commits full pattern at store location.
// - equal store and readback locations give no guaranteed pattern.
// - setting option bit 6 selects acquisition test, rearms FIFO write.
// - clearing bit 6 rearms FIFO read pointer and releases writes.
// - test FIFO is circular; host writes exactly sixteen words.
// - setting bit 6 again rearms write and releases reads.
// - each gate in acquisition test moves FIFO words out as an event.
// - test word is a 12-bit value plus an overflow flag.
// - acceptance compares 8-bit threshold with upper 8 value bits.
module paac_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic gatePin,
	input wire logic fastClearPin,
	input wire logic [11:0] adcValue,
	input wire logic adcOverflow,
	input wire logic regSel,
	input wire logic regWrite,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWdata,
	output logic [31:0] regRdata,
	output logic regAck,
	output logic busy,
	output logic dataReadyIndicator,
	output logic qacStart,
	output logic holdClear,
	output logic [3:0] holdSelect,
	output logic [2:0] irqLevel,
	output logic [7:0] irqVector,
	output logic [7:0] chainGroupBase
);
	localparam int SW = paac_pkg::SLOT_BITS;
	localparam int WW = paac_pkg::WORD_BITS;
	localparam int AW = paac_pkg::BUF_AW;
	localparam logic [7:0] CHARGE_LOAD = 8'(paac_pkg::CHARGE_CYC - 1);
	localparam logic [7:0] SAMPLE_LOAD = 8'(paac_pkg::SAMPLE_CYC - 1);
	localparam logic [5:0] MES_FULL = 6'(paac_pkg::MES_EVENTS);

	paac_pkg::paac_state_t state_r, state_nxt;
	logic [1:0] sync1_r, sync2_r, sync3_r, level_r;
	logic [1:0] pinIn, pinEdge;
	logic gateEdge, fcEdge, startReq;
	logic [7:0] timer_r;
	logic [3:0] idx_r;
	logic [5:0] nAcc_r, nAccNext;
	logic accept, sampleNow;
	logic [12:0] sample, fifoData;
	logic [8:0] thrMem [0:15];
	logic [15:0] options_r, testHigh_r;
	logic [AW-1:0] wTestAddr_r, rTestAddr_r;
	logic [23:0] evCount_r;
	logic [SW-1:0] wrSlot_r, rdSlot_r;
	logic [WW-1:0] rdWord_r;
	logic [5:0] evStored_r;
	logic memWe, obRead_r, obEmpty_r, advRead;
	logic [AW-1:0] memWaddr, memRaddr;
	logic [31:0] memWdata, memRdata;
	logic [1:0] ackPipe_r;
	logic [15:0] rdAddr_r;
	logic wrHit, rdHit, memTest, acqTest, emptyEn, countAll;

	// true when the bus addresses a given register
	function automatic logic at(input logic [15:0] a, input logic [15:0] o);
		return a == o;
	endfunction : at

	// output order: ch0H ch4H ch0L ch4L ch1H ... ch7L
	function automatic logic [3:0] thrIndex(input logic [3:0] k);
		return {k[0], k[3:2], k[1]};
	endfunction : thrIndex

	assign wrHit = regSel && regWrite;
	assign rdHit = regSel && !regWrite;
	assign memTest = options_r[paac_pkg::BIT_MEM_TEST];
	assign acqTest = options_r[paac_pkg::BIT_ACQ_TEST];
	assign emptyEn = options_r[paac_pkg::BIT_EMPTY_EN];
	assign countAll = options_r[paac_pkg::BIT_COUNT_ALL];

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers, a change counts once stages two and three agree
	assign pinIn = {fastClearPin, gatePin};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
					sync3_r[gi] <= 1'b0;
					level_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= pinIn[gi];
					sync2_r[gi] <= sync1_r[gi];
					sync3_r[gi] <= sync2_r[gi];
					if (sync2_r[gi] == sync3_r[gi]) begin
						level_r[gi] <= sync3_r[gi];
					end
				end
			end
			assign pinEdge[gi] = (sync2_r[gi] == sync3_r[gi]) && sync3_r[gi] && !level_r[gi];
		end
	endgenerate
	assign gateEdge = pinEdge[0];
	assign fcEdge = pinEdge[1];
	// software conversion acts as a gate
	assign startReq = gateEdge || (wrHit && at(regAddr, paac_pkg::OFF_SW_COMM));

	////////////////////////////////////////////////////////////////////////////
	// sample path: converter or test FIFO word
	// test mode takes each FIFO word as an accepted sample
	// 12-bit value with overflow flag on top
	assign sample = acqTest ? fifoData : {adcOverflow, adcValue};
	assign sampleNow = (state_r == paac_pkg::ST_CONV) && (timer_r == 8'h00);
	// upper 8 value bits against threshold, kill drops channel
	assign accept = acqTest || (!thrMem[thrIndex(idx_r)][paac_pkg::KILL_BIT]
		&& (sample[11:4] >= thrMem[thrIndex(idx_r)][7:0]));
	assign nAccNext = nAcc_r + {5'h00, accept};

	////////////////////////////////////////////////////////////////////////////
	// acquisition sequencer next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			paac_pkg::ST_IDLE: begin
				if (startReq) begin
					state_nxt = paac_pkg::ST_CHARGE;
				end
			end
			paac_pkg::ST_CHARGE: begin
				if (fcEdge) begin
					state_nxt = paac_pkg::ST_IDLE;
				end else if (timer_r == 8'h00) begin
					state_nxt = paac_pkg::ST_CONV;
				end
			end
			paac_pkg::ST_CONV: begin
				if (sampleNow && idx_r == 4'hF) begin
					// empty event with option clear stores nothing
					// empty event with option set keeps header and trailer
					if (nAccNext != 6'h00 || emptyEn) begin
						state_nxt = paac_pkg::ST_HDR;
					end else begin
						state_nxt = paac_pkg::ST_IDLE;
					end
				end
			end
			paac_pkg::ST_HDR: begin
				state_nxt = paac_pkg::ST_TRL;
			end
			paac_pkg::ST_TRL: begin
				if (evStored_r + 6'h01 == MES_FULL) begin
					state_nxt = paac_pkg::ST_FULL;
				end else begin
					state_nxt = paac_pkg::ST_IDLE;
				end
			end
			paac_pkg::ST_FULL: begin
				if (evStored_r != MES_FULL) begin
					state_nxt = paac_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = paac_pkg::ST_IDLE;
			end
		endcase
	end

	// state register and control outputs
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= paac_pkg::ST_IDLE;
			busy <= 1'b0;
			qacStart <= 1'b0;
			holdClear <= 1'b0;
		end else begin
			state_r <= state_nxt;
			busy <= (state_nxt != paac_pkg::ST_IDLE);
			qacStart <= (state_r == paac_pkg::ST_IDLE) && (state_nxt == paac_pkg::ST_CHARGE);
			// holds cleared when the module frees up
			holdClear <= (state_r != paac_pkg::ST_IDLE) && (state_nxt == paac_pkg::ST_IDLE);
		end
	end

	// charge and sample timers, hold stage walk
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			timer_r <= 8'h00;
			idx_r <= 4'h0;
			nAcc_r <= 6'h00;
		end else if (state_r == paac_pkg::ST_IDLE) begin
			timer_r <= CHARGE_LOAD;
			idx_r <= 4'h0;
			nAcc_r <= 6'h00;
		end else if (state_r == paac_pkg::ST_CHARGE) begin
			timer_r <= (timer_r == 8'h00) ? SAMPLE_LOAD : timer_r - 8'h01;
		end else if (state_r == paac_pkg::ST_CONV) begin
			// each hold stage settles, then is sampled
			if (sampleNow) begin
				timer_r <= SAMPLE_LOAD;
				idx_r <= idx_r + 4'h1;
				nAcc_r <= nAccNext;
			end else begin
				timer_r <= timer_r - 8'h01;
			end
		end
	end
	assign holdSelect = idx_r;

	////////////////////////////////////////////////////////////////////////////
	// event counter
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			evCount_r <= 24'h000000;
		end else if (wrHit && at(regAddr, paac_pkg::OFF_EVCNT_RESET)) begin
			evCount_r <= 24'h000000;
		end else if (countAll && state_r == paac_pkg::ST_IDLE && startReq) begin
			evCount_r <= evCount_r + 24'h000001;
		end else if (!countAll && state_r == paac_pkg::ST_HDR && nAcc_r != 6'h00) begin
			evCount_r <= evCount_r + 24'h000001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// store pointers and occupancy
	assign advRead = obRead_r && !obEmpty_r && !memTest;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			// store empty, both pointers on buffer zero
			wrSlot_r <= '0;
			rdSlot_r <= '0;
			rdWord_r <= '0;
			evStored_r <= 6'h00;
		end else begin
			if (state_r == paac_pkg::ST_TRL) begin
				wrSlot_r <= wrSlot_r + 1'b1;
			end
			if (advRead && memRdata[paac_pkg::TYPE_LSB+:3] == paac_pkg::TYPE_TRL) begin
				rdSlot_r <= rdSlot_r + 1'b1;
				rdWord_r <= '0;
			end else if (advRead) begin
				rdWord_r <= rdWord_r + 1'b1;
			end
			evStored_r <= evStored_r + {5'h00, state_r == paac_pkg::ST_TRL}
				- {5'h00, advRead && memRdata[paac_pkg::TYPE_LSB+:3] == paac_pkg::TYPE_TRL};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// store write port: acquisition first, then memory test
	always_comb begin
		memWe = 1'b0;
		memWaddr = '0;
		memWdata = '0;
		if (sampleNow && accept) begin
			// data words follow the header slot
			memWe = 1'b1;
			memWaddr = {wrSlot_r, WW'(nAcc_r + 6'h01)};
			memWdata = {5'h00, paac_pkg::TYPE_DATA, 3'h0, thrIndex(idx_r), 4'h0, sample};
		end else if (state_r == paac_pkg::ST_HDR) begin
			memWe = 1'b1;
			memWaddr = {wrSlot_r, WW'(0)};
			memWdata = {5'h00, paac_pkg::TYPE_HDR, 10'h000, nAcc_r, 8'h00};
		end else if (state_r == paac_pkg::ST_TRL) begin
			memWe = 1'b1;
			memWaddr = {wrSlot_r, WW'(nAcc_r + 6'h01)};
			memWdata = {5'h00, paac_pkg::TYPE_TRL, evCount_r};
		end else if (memTest && wrHit && at(regAddr, paac_pkg::OFF_TESTWORD_LO)) begin
			// low half commits the whole pattern
			memWe = 1'b1;
			memWaddr = wTestAddr_r;
			memWdata = {testHigh_r, regWdata};
		end
	end
	// memory test reads at the chosen location
	assign memRaddr = memTest ? rTestAddr_r : {rdSlot_r, rdWord_r};

	paac_out_mem #(.AW(AW), .DW(32)) u_store (
		.mclk(mclk),
		.we(memWe),
		.waddr(memWaddr),
		.wdata(memWdata),
		.raddr(memRaddr),
		.rdata(memRdata)
	);

	// test words written through their own register
	paac_test_fifo #(.DW(paac_pkg::FIFO_DW), .DEPTH_LG(4)) u_test_fifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.acqTest(acqTest),
		.wrEn(wrHit && at(regAddr, paac_pkg::OFF_TEST_EVENT)),
		.wrData(regWdata[12:0]),
		.rdEn(sampleNow && acqTest),
		.rdData(fifoData)
	);

	////////////////////////////////////////////////////////////////////////////
	// software written registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			options_r <= paac_pkg::RST_OPTIONS;
			irqLevel <= paac_pkg::RST_IRQ_LEVEL;
			irqVector <= paac_pkg::RST_IRQ_VECTOR;
			chainGroupBase <= paac_pkg::RST_CHAIN;
			testHigh_r <= 16'h0000;
			wTestAddr_r <= '0;
			rTestAddr_r <= '0;
		end else if (wrHit) begin
			// option bit set path selects acquisition test
			if (at(regAddr, paac_pkg::OFF_BITSET2)) begin
				options_r <= options_r | regWdata;
			end
			if (at(regAddr, paac_pkg::OFF_BITCLR2)) begin
				options_r <= options_r & ~regWdata;
			end
			if (at(regAddr, paac_pkg::OFF_IRQ_LEVEL)) begin
				irqLevel <= regWdata[2:0];
			end
			if (at(regAddr, paac_pkg::OFF_IRQ_VECTOR)) begin
				irqVector <= regWdata[7:0];
			end
			if (at(regAddr, paac_pkg::OFF_CHAIN)) begin
				chainGroupBase <= regWdata[7:0];
			end
			if (at(regAddr, paac_pkg::OFF_TESTWORD_HI)) begin
				testHigh_r <= regWdata;
			end
			if (at(regAddr, paac_pkg::OFF_WTEST_ADDR)) begin
				wTestAddr_r <= regWdata[AW-1:0];
			end
			// no interlock between the two test locations
			if (at(regAddr, paac_pkg::OFF_RTEST_ADDR)) begin
				rTestAddr_r <= regWdata[AW-1:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (wrHit && regAddr >= paac_pkg::OFF_THR_FIRST && regAddr <= paac_pkg::OFF_THR_LAST) begin
			thrMem[regAddr[5:2]] <= regWdata[8:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read path: address held, store data arrive a cycle later
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ackPipe_r <= 2'b00;
			rdAddr_r <= 16'h0000;
			obRead_r <= 1'b0;
			obEmpty_r <= 1'b1;
			regAck <= 1'b0;
			regRdata <= 32'h0000_0000;
			dataReadyIndicator <= 1'b0;
		end else begin
			ackPipe_r <= {ackPipe_r[0], regSel};
			rdAddr_r <= regAddr;
			obRead_r <= rdHit && regAddr <= paac_pkg::OFF_OUTBUF_LAST;
			obEmpty_r <= (evStored_r == 6'h00);
			regAck <= ackPipe_r[0];
			dataReadyIndicator <= (evStored_r != 6'h00);
			if (obRead_r) begin
				regRdata <= (obEmpty_r && !memTest) ? paac_pkg::INVALID_WORD : memRdata;
			end else if (at(rdAddr_r, paac_pkg::OFF_STATUS)) begin
				regRdata <= {29'h0, evStored_r == MES_FULL, evStored_r != 6'h00, busy};
			end else if (at(rdAddr_r, paac_pkg::OFF_EVCNT)) begin
				regRdata <= {8'h00, evCount_r};
			end else if (at(rdAddr_r, paac_pkg::OFF_BITSET2)) begin
				regRdata <= {16'h0000, options_r};
			end else if (at(rdAddr_r, paac_pkg::OFF_CHAIN)) begin
				regRdata <= {24'h000000, chainGroupBase};
			end else begin
				regRdata <= 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence sGateTaken;
		(state_r == paac_pkg::ST_IDLE) && gateEdge;
	endsequence
	sequence sEventSaved;
		(state_r == paac_pkg::ST_HDR) ##1 (state_r == paac_pkg::ST_TRL);
	endsequence
	a_gate_start_busy: assert property (sGateTaken |=> busy && qacStart)
		else $error("gate while idle did not raise busy");
	a_busy_gate_ignored: assert property ((state_r == paac_pkg::ST_CONV) && gateEdge
		|=> state_r != paac_pkg::ST_CHARGE && $stable(evCount_r))
		else $error("gate during busy had an effect");
	a_abort_on_clear: assert property ((state_r == paac_pkg::ST_CHARGE) && fcEdge
		|=> state_r == paac_pkg::ST_IDLE && holdClear && !busy)
		else $error("fast clear did not abort charge conversion");
	a_header_trailer: assert property (sEventSaved |-> $past(memWe) && memWe
		&& memWdata[paac_pkg::TYPE_LSB+:3] == paac_pkg::TYPE_TRL)
		else $error("event not framed by header and trailer");
	a_empty_skip: assert property (sampleNow && idx_r == 4'hF && nAccNext == 6'h00 && !emptyEn
		|=> state_r == paac_pkg::ST_IDLE)
		else $error("empty event was stored");
	a_empty_frame: assert property (sampleNow && idx_r == 4'hF && nAccNext == 6'h00 && emptyEn
		|=> state_r == paac_pkg::ST_HDR ##1 state_r == paac_pkg::ST_TRL)
		else $error("empty event lost its header and trailer");
	a_full_busy: assert property ((state_r == paac_pkg::ST_FULL) |-> busy)
		else $error("busy dropped while store full");
	a_test_commit: assert property (memTest && wrHit && at(regAddr, paac_pkg::OFF_TESTWORD_LO)
		&& state_r == paac_pkg::ST_IDLE |-> memWe && memWaddr == wTestAddr_r)
		else $error("low test half did not commit pattern");
	a_chain_hold: assert property (!$stable(chainGroupBase)
		|-> $past(wrHit && at(regAddr, paac_pkg::OFF_CHAIN)))
		else $error("chain group base changed without a write");
	a_ready_flag: assert property ((evStored_r != 6'h00) |=> dataReadyIndicator)
		else $error("data ready not shown for stored event");
endmodule : paac_top

/* File: rtl/paac_pkg.sv */
package paac_pkg;
	// clock and timing
	localparam int CLK_MHZ = 100;
	localparam int CHARGE_TIME_NS = 1000;
	localparam int CHARGE_CYC = (CHARGE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int SAMPLE_TIME_NS = 100;
	localparam int SAMPLE_CYC = (SAMPLE_TIME_NS * CLK_MHZ + 999) / 1000;
	// event geometry
	localparam int NUM_WORDS = 16;
	localparam int SLOT_BITS = 5;
	localparam int WORD_BITS = 6;
	localparam int BUF_AW = 11;
	localparam int MES_EVENTS = 32;
	localparam int FIFO_DW = 13;
	// register offsets
	localparam logic [15:0] OFF_OUTBUF_LAST = 16'h0FFC;
	localparam logic [15:0] OFF_CHAIN = 16'h1004;
	localparam logic [15:0] OFF_IRQ_LEVEL = 16'h100A;
	localparam logic [15:0] OFF_IRQ_VECTOR = 16'h100C;
	localparam logic [15:0] OFF_STATUS = 16'h100E;
	localparam logic [15:0] OFF_EVCNT = 16'h1024;
	localparam logic [15:0] OFF_BITSET2 = 16'h1032;
	localparam logic [15:0] OFF_BITCLR2 = 16'h1034;
	localparam logic [15:0] OFF_WTEST_ADDR = 16'h1036;
	localparam logic [15:0] OFF_TESTWORD_HI = 16'h1038;
	localparam logic [15:0] OFF_TESTWORD_LO = 16'h103A;
	localparam logic [15:0] OFF_TEST_EVENT = 16'h103E;
	localparam logic [15:0] OFF_EVCNT_RESET = 16'h1040;
	localparam logic [15:0] OFF_RTEST_ADDR = 16'h1064;
	localparam logic [15:0] OFF_SW_COMM = 16'h1068;
	localparam logic [15:0] OFF_THR_FIRST = 16'h1080;
	localparam logic [15:0] OFF_THR_LAST = 16'h10BE;
	// option bit positions
	localparam int BIT_MEM_TEST = 0;
	localparam int BIT_ACQ_TEST = 6;
	localparam int BIT_EMPTY_EN = 12;
	localparam int BIT_COUNT_ALL = 14;
	// reset values
	localparam logic [7:0] RST_CHAIN = 8'hAA;
	localparam logic [2:0] RST_IRQ_LEVEL = 3'h0;
	localparam logic [7:0] RST_IRQ_VECTOR = 8'h00;
	localparam logic [15:0] RST_OPTIONS = 16'h0000;
	// output word layout
	localparam int TYPE_LSB = 24;
	localparam logic [2:0] TYPE_DATA = 3'h0;
	localparam logic [2:0] TYPE_HDR = 3'h2;
	localparam logic [2:0] TYPE_TRL = 3'h4;
	localparam logic [31:0] INVALID_WORD = 32'h0600_0000;
	localparam int CHAN_LSB = 17;
	localparam int CNT_LSB = 8;
	localparam int KILL_BIT = 8;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CHARGE = 3'b001,
		ST_CONV = 3'b011,
		ST_HDR = 3'b010,
		ST_TRL = 3'b110,
		ST_FULL = 3'b111
	} paac_state_t;
endpackage : paac_pkg

/* File: rtl/paac_out_mem.sv */
`timescale 1ns/1ps
module paac_out_mem #(
	parameter int AW = 11,
	parameter int DW = 32
) (
	input wire logic mclk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	// single write port, registered read port
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : paac_out_mem

/* File: rtl/paac_test_fifo.sv */
`timescale 1ns/1ps
module paac_test_fifo #(
	parameter int DW = 13,
	parameter int DEPTH_LG = 4
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic acqTest,
	input wire logic wrEn,
	input wire logic [DW-1:0] wrData,
	input wire logic rdEn,
	output logic [DW-1:0] rdData
);
	logic [DW-1:0] mem [0:(1<<DEPTH_LG)-1];
	logic [DEPTH_LG-1:0] wrPtr_r;
	logic [DEPTH_LG-1:0] rdPtr_r;
	logic acqTestD_r;

	// mode edge tracking
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			acqTestD_r <= 1'b0;
		end else begin
			acqTestD_r <= acqTest;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_r <= '0;
		end else if (acqTest && !acqTestD_r) begin
			wrPtr_r <= '0;
		end else if (!acqTest && wrEn) begin
			wrPtr_r <= wrPtr_r + 1'b1;
		end
	end

	// circular store, no reset of contents
	always_ff @(posedge mclk) begin
		if (!acqTest && wrEn) begin
			mem[wrPtr_r] <= wrData;
		end
		rdData <= mem[rdPtr_r];
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdPtr_r <= '0;
		end else if (!acqTest && acqTestD_r) begin
			rdPtr_r <= '0;
		end else if (acqTest && rdEn) begin
			rdPtr_r <= rdPtr_r + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_wrptr_rearm: assert property ($rose(acqTest) |=> wrPtr_r == '0)
		else $error("write pointer not rearmed on test select");
	a_rdptr_rearm: assert property ($fell(acqTest) |=> rdPtr_r == '0)
		else $error("read pointer not rearmed on test deselect");
	a_rdptr_step: assert property (acqTest && acqTestD_r && rdEn |=>
		rdPtr_r == $past(rdPtr_r) + 1'b1)
		else $error("read pointer did not advance in test mode");
endmodule : paac_test_fifo

/* File: tb/paac_adc_model.sv */
`timescale 1ns/1ps
// converter stand-in: one fixed result for each hold stage
module paac_adc_model #(
	parameter logic [11:0] FIRST_VAL = 12'h123
) (
	input wire logic [3:0] holdSelect,
	output logic [11:0] adcValue,
	output logic adcOverflow
);
	// stage zero is large, the rest stay below any sane threshold
	assign adcValue = (holdSelect == 4'h0) ? FIRST_VAL : 12'h010;
	assign adcOverflow = 1'h0;
endmodule : paac_adc_model

/* File: tb/paac_top_tb_top.sv */
`timescale 1ns/1ps
module paac_top_tb_top;
	logic mclk, rst_n, gatePin, fastClearPin, adcOverflow, regSel, regWrite, regAck, busy;
	logic dataReadyIndicator, qacStart, holdClear;
	logic [11:0] adcValue;
	logic [15:0] regAddr, regWdata;
	logic [31:0] regRdata, rd;
	logic [3:0] holdSelect;
	logic [2:0] irqLevel;
	logic [7:0] irqVector, chainGroupBase;
	int failures = 0;
	int nTests = 0;
	int cyc = 0;
	typedef struct packed {logic [15:0] a; logic [31:0] e;} paac_row_t;
	paac_row_t rows [6] = '{{16'h100A, 32'h0}, {16'h100C, 32'h0}, {16'h1004, 32'hAA},
		{16'h1024, 32'h0}, {16'h0000, 32'h0600_0000}, {16'h2000, 32'h0}};

	paac_top uut (.mclk, .rst_n, .gatePin, .fastClearPin, .adcValue, .adcOverflow, .regSel,
		.regWrite, .regAddr, .regWdata, .regRdata, .regAck, .busy, .dataReadyIndicator,
		.qacStart, .holdClear, .holdSelect, .irqLevel, .irqVector, .chainGroupBase);
	paac_adc_model adc (.holdSelect, .adcValue, .adcOverflow);

	////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 10000) begin
			failures++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// compare, register access, gate and wait helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk) #1;
		regSel = 1'h1;
		regWrite = w;
		regAddr = a;
		regWdata = d;
		@(posedge mclk) #1;
		regSel = 1'h0;
		for (int i = 0; i < 6; i++) begin
			@(posedge mclk) #1;
			if (regAck === 1'h1) break;
		end
		rd = regRdata;
	endtask : acc
	task automatic gate();
		@(posedge mclk) #1;
		gatePin = 1'h1;
		repeat (5) @(posedge mclk);
		#1 gatePin = 1'h0;
	endtask : gate
	task automatic waitIdle(input int lim);
		for (int i = 0; i < lim; i++) begin
			@(posedge mclk) #1;
			if (busy === 1'h0) break;
		end
	endtask : waitIdle
	task automatic conclude();
		$display("tests=%0d failures=%0d", nTests, failures);
		if (failures == 0 && nTests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst_n = 1'h0;
		gatePin = 1'h0;
		fastClearPin = 1'h0;
		regSel = 1'h0;
		regWrite = 1'h0;
		regAddr = 16'h0;
		regWdata = 16'h0;
		repeat (20) @(posedge mclk);
		#1 rst_n = 1'h1;
		chk({irqLevel, irqVector, chainGroupBase, busy, dataReadyIndicator}, 21'h0002A8);
		foreach (rows[i]) begin
			acc(1'h0, rows[i].a, 16'h0);
			chk(rd, rows[i].e);
		end
		for (int i = 0; i < 16; i++) acc(1'h1, 16'h1080 + 16'(4 * i), 16'h00FF);
		acc(1'h1, 16'h1032, 16'h4000);
		gate();
		chk(busy, 1);
		repeat (120) @(posedge mclk);
		gate();
		waitIdle(600);
		chk({busy, dataReadyIndicator}, 0);
		acc(1'h0, 16'h1024, 16'h0);
		chk(rd, 1);
		acc(1'h1, 16'h1032, 16'h1000);
		gate();
		waitIdle(600);
		acc(1'h0, 16'h0, 16'h0);
		chk({rd[26:24], rd[13:8]}, {3'h2, 6'h00});
		acc(1'h0, 16'h0, 16'h0);
		chk(rd[26:24], 3'h4);
		acc(1'h1, 16'h1080, 16'h0000);
		gate();
		waitIdle(600);
		acc(1'h0, 16'h0, 16'h0);
		chk({rd[26:24], rd[13:8]}, {3'h2, 6'h01});
		acc(1'h0, 16'h0, 16'h0);
		chk({rd[26:24], rd[20:17], rd[12:0]}, {3'h0, 4'h0, 13'h0123});
		acc(1'h0, 16'h0, 16'h0);
		chk(rd[26:24], 3'h4);
		gate();
		repeat (10) @(posedge mclk);
		#1 fastClearPin = 1'h1;
		repeat (5) @(posedge mclk);
		#1 fastClearPin = 1'h0;
		waitIdle(40);
		chk({busy, dataReadyIndicator}, 0);
		acc(1'h1, 16'h1032, 16'h0040);
		acc(1'h1, 16'h1034, 16'h0040);
		for (int i = 0; i < 16; i++) acc(1'h1, 16'h103E, {3'h0, i[0], 4'hA, i[3:0], 4'h5});
		acc(1'h1, 16'h1032, 16'h0040);
		gate();
		waitIdle(600);
		acc(1'h0, 16'h0, 16'h0);
		chk({rd[26:24], rd[13:8]}, {3'h2, 6'h10});
		for (int i = 0; i < 16; i++) begin
			acc(1'h0, 16'h0, 16'h0);
			chk(rd[12:0], {i[0], 4'hA, i[3:0], 4'h5});
		end
		acc(1'h0, 16'h0, 16'h0);
		chk(rd[26:24], 3'h4);
		acc(1'h1, 16'h1034, 16'h0040);
		acc(1'h0, 16'h1032, 16'h0);
		chk(rd[6], 1'h0);
		// random access test, locations kept apart
		acc(1'h1, 16'h1032, 16'h0001);
		acc(1'h1, 16'h1036, 16'h0010);
		acc(1'h1, 16'h1064, 16'h0020);
		acc(1'h1, 16'h1038, 16'hC3A5);
		acc(1'h1, 16'h103A, 16'h5A3C);
		acc(1'h1, 16'h1036, 16'h0030);
		acc(1'h1, 16'h1064, 16'h0010);
		acc(1'h0, 16'h0000, 16'h0);
		chk(rd, 32'hC3A5_5A3C);
		acc(1'h1, 16'h1034, 16'h0001);
		conclude();
	end
endmodule : paac_top_tb_top
